// ==== logic/prsc_ctl_regs.vh ====
// register offsets, field positions, reset values and timing counts of the power/slow-clock block
`ifndef PRSC_CTL_REGS_VH
`define PRSC_CTL_REGS_VH
`define PRSC_ADDR_W 8
`define PRSC_OFF_EXT_INT_FLAGS 8'h91
`define PRSC_OFF_POWER_MGMT 8'hC4
`define PRSC_OFF_POWER_STATUS 8'hC5
`define PRSC_OFF_WATCHDOG_CTL 8'hC6
`define PRSC_OFF_IRQ_CTL 8'hC7
`define PRSC_PMR_DIV_HI 7
`define PRSC_PMR_DIV_LO 6
`define PRSC_PMR_AUTO_RET 5
`define PRSC_PMR_XTAL_OFF 3
`define PRSC_ST_PF_IP 7
`define PRSC_ST_HI_IP 6
`define PRSC_ST_LO_IP 5
`define PRSC_ST_XTAL_UP 4
`define PRSC_ST_TX_ACT 1
`define PRSC_ST_RX_ACT 0
`define PRSC_EXT_INTERRUPT_FLAGS_XTAL_SEL 3
`define PRSC_EXT_INTERRUPT_FLAGS_RING_ACT 2
`define PRSC_WDC_POR 6
`define PRSC_DIV_RSVD 2'h0
`define PRSC_DIV_4 2'h1
`define PRSC_DIV_64 2'h2
`define PRSC_DIV_1024 2'h3
`define PRSC_CNT_4 10'h003
`define PRSC_CNT_64 10'h03F
`define PRSC_CNT_1024 10'h3FF
`define PRSC_OSC_CYCLES 65536
`define PRSC_RESET_VECTOR 16'h0000
`endif

// ==== logic/prsc_power_clock_ctl.v ====
// power-fail reset sequencer, slow-clock divider and switchback with an Avalon-MM register slave
//
// Our own choice: the Avalon-MM register port.
`timescale 1ns/1ns
`include "prsc_ctl_regs.vh"

module prsc_power_clock_ctl #(
  parameter OSC_CYCLES = `PRSC_OSC_CYCLES,
  parameter XTAL_WARM_CYCLES = `PRSC_OSC_CYCLES,
  parameter NUM_EXT_INT = 6
) (
  input wire clk,
  input wire reset,
  input wire [`PRSC_ADDR_W-1:0] address,
  input wire read,
  input wire write,
  input wire [7:0] writedata,
  output reg [7:0] readdata,
  output wire waitrequest,
  input wire supplyLowPin,
  output reg sysResetOutN,
  output reg coreReset,
  output reg ioReset,
  output reg xtalEnable,
  output reg [15:0] resetVector,
  output reg cycleTick,
  output reg [1:0] divSelOut,
  output reg ringSelect,
  input wire [NUM_EXT_INT-1:0] extIntPin,
  input wire [NUM_EXT_INT-1:0] extIntEnable,
  input wire [NUM_EXT_INT-1:0] extIntHighPri,
  input wire globalIntEnable,
  input wire pfInService,
  input wire hiInService,
  input wire loInService,
  input wire serialRxPin,
  input wire serialRxEnable,
  input wire serialRxActive,
  input wire serialTxActive
);
  localparam ST_PWROFF = 3'b001;
  localparam ST_WARM = 3'b010;
  localparam ST_RUN = 3'b100;

  reg [2:0] state_ff;
  reg [2:0] nxt_state;
  reg [16:0] oscCnt_ff;
  reg [16:0] nxt_oscCnt;
  reg [16:0] xtalCnt_ff;
  reg xtalUp_ff;
  reg supplyMeta_ff;
  reg supplyLow_ff;
  reg [NUM_EXT_INT-1:0] intMeta_ff;
  reg [NUM_EXT_INT-1:0] intSync_ff;
  reg rxMeta_ff;
  reg rxSync_ff;
  reg rxPrev_ff;
  reg [1:0] divSel_ff;
  reg [1:0] divPend_ff;
  reg pendValid_ff;
  reg [9:0] cycCnt_ff;
  reg autoRet_ff;
  reg xtalOff_ff;
  reg xtalSel_ff;
  reg porFlag_ff;
  reg serialBusy_ff;
  reg ackPhase_ff;
  reg [9:0] divMax;
  wire [NUM_EXT_INT-1:0] intServiceable;
  wire intSwitch;
  wire startEdge;
  wire switchBack;
  wire busReq;
  wire wrPmr;
  wire [1:0] wrDiv;
  wire serialLock;
  wire divWriteOk;
  wire busDone;
  wire wrExif;
  wire wrWdc;
  wire rdTake;
  wire reducedReq;
  wire slowNow;
  wire [7:0] pmrView;
  wire [7:0] statusView;
  wire [7:0] exifView;
  wire [7:0] wdcView;

  // bus answers one cycle after the request: waitrequest high in the first cycle
  assign busReq = read | write;
  assign waitrequest = busReq & ~ackPhase_ff;
  // a fixed single wait state lets read data come straight from a flop
  assign busDone = busReq & ackPhase_ff;
  // read data is captured on the first edge, so it stands through the answer cycle
  assign rdTake = read & ~ackPhase_ff;

  always @(posedge clk) begin
    if (reset) begin
      ackPhase_ff <= 1'b0;
    end else begin
      ackPhase_ff <= busReq & ~ackPhase_ff;
    end
  end

  // pin inputs pass two flops before any logic
  // reset values match the idle pin levels, so no false start bit follows reset
  always @(posedge clk) begin
    if (reset) begin
      supplyMeta_ff <= 1'b1;
      supplyLow_ff <= 1'b1;
      intMeta_ff <= {NUM_EXT_INT{1'b0}};
      intSync_ff <= {NUM_EXT_INT{1'b0}};
      rxMeta_ff <= 1'b1;
      rxSync_ff <= 1'b1;
      rxPrev_ff <= 1'b1;
    end else begin
      supplyMeta_ff <= supplyLowPin;
      supplyLow_ff <= supplyMeta_ff;
      intMeta_ff <= extIntPin;
      intSync_ff <= intMeta_ff;
      rxMeta_ff <= serialRxPin;
      rxSync_ff <= rxMeta_ff;
      rxPrev_ff <= rxSync_ff;
    end
  end

  // power sequencing
  // a supply dip during warm-up restarts the whole count; a partial count is never trusted
  always @* begin
    nxt_state = state_ff;
    nxt_oscCnt = oscCnt_ff;
    case (state_ff)
      ST_PWROFF: begin
        nxt_oscCnt = 17'h00000;
        if (!supplyLow_ff) begin
          nxt_state = ST_WARM;
        end
      end
      ST_WARM: begin
        nxt_oscCnt = oscCnt_ff + 17'h00001;
        if (supplyLow_ff) begin
          nxt_state = ST_PWROFF;
        end else if (oscCnt_ff == OSC_CYCLES[16:0] - 17'h00001) begin
          nxt_state = ST_RUN;
        end
      end
      ST_RUN: begin
        if (supplyLow_ff) begin
          nxt_state = ST_PWROFF;
        end
      end
      default: begin
        nxt_state = ST_PWROFF;
      end
    endcase
  end

  always @(posedge clk) begin
    if (reset) begin
      state_ff <= ST_PWROFF;
      oscCnt_ff <= 17'h00000;
      sysResetOutN <= 1'b0;
      coreReset <= 1'b1;
      ioReset <= 1'b1;
      xtalEnable <= 1'b0;
      resetVector <= `PRSC_RESET_VECTOR;
    end else begin
      state_ff <= nxt_state;
      oscCnt_ff <= nxt_oscCnt;
      sysResetOutN <= (nxt_state == ST_RUN);
      coreReset <= (nxt_state != ST_RUN);
      ioReset <= (nxt_state != ST_RUN);
      xtalEnable <= (nxt_state != ST_PWROFF) & ~xtalOff_ff;
      resetVector <= `PRSC_RESET_VECTOR;
    end
  end

  // switchback triggers on the undivided clock
  // enables and in-service levels come from core logic on this clock, so they need no sync
  genvar gi;
  generate
    for (gi = 0; gi < NUM_EXT_INT; gi = gi + 1) begin : gIntQual
      // high-priority source needs no high/pf in service; low needs none at all
      assign intServiceable[gi] = intSync_ff[gi] & extIntEnable[gi] & globalIntEnable &
        ~pfInService & (extIntHighPri[gi] ? ~hiInService : ~(hiInService | loInService));
    end
  endgenerate

  // a level, not an edge: a request held high keeps the rate at four clocks
  assign intSwitch = |intServiceable;
  assign startEdge = rxPrev_ff & ~rxSync_ff & serialRxEnable;
  assign switchBack = autoRet_ff & (intSwitch | startEdge);

  // serial activity latch: a start bit marks the port busy until the receiver settles
  always @(posedge clk) begin
    if (reset) begin
      serialBusy_ff <= 1'b0;
    end else if (autoRet_ff & startEdge) begin
      serialBusy_ff <= 1'b1;
    end else if (!serialRxActive && rxSync_ff) begin
      serialBusy_ff <= 1'b0;
    end
  end

  // writes land on the edge that ends the answer cycle after the wait state
  assign wrPmr = write & busDone & (address == `PRSC_OFF_POWER_MGMT);
  assign wrExif = write & busDone & (address == `PRSC_OFF_EXT_INT_FLAGS);
  assign wrWdc = write & busDone & (address == `PRSC_OFF_WATCHDOG_CTL);
  assign wrDiv = writedata[`PRSC_PMR_DIV_HI:`PRSC_PMR_DIV_LO];
  // the reserved code is neither a reduced rate nor the full rate, so it falls through
  assign reducedReq = (wrDiv == `PRSC_DIV_64) | (wrDiv == `PRSC_DIV_1024);
  assign slowNow = (divSel_ff != `PRSC_DIV_4);
  // lock lasts until the line idles; a line stuck low keeps the full rate, which is safe
  assign serialLock = serialRxActive | serialTxActive | (autoRet_ff & serialBusy_ff);
  // reduced rates only from the settled 4-clock rate and with the serial port idle
  assign divWriteOk = (wrDiv == `PRSC_DIV_4) |
    (reducedReq && !slowNow && !pendValid_ff &&
    !serialLock);

  always @* begin
    case (divSel_ff)
      `PRSC_DIV_64: divMax = `PRSC_CNT_64;
      `PRSC_DIV_1024: divMax = `PRSC_CNT_1024;
      default: divMax = `PRSC_CNT_4;
    endcase
  end

  // divider: one tick per instruction cycle; a pending choice lands at a cycle end
  // landing only at a cycle end means a pending choice never gives a half-length slow cycle; a switchback cuts the slow count short
  always @(posedge clk) begin
    if (reset || coreReset) begin
      divSel_ff <= `PRSC_DIV_4;
      divPend_ff <= `PRSC_DIV_4;
      pendValid_ff <= 1'b0;
      cycCnt_ff <= 10'h000;
      cycleTick <= 1'b0;
    end else begin
      cycleTick <= (cycCnt_ff == divMax);
      if (switchBack) begin
        divSel_ff <= `PRSC_DIV_4;
        pendValid_ff <= 1'b0;
        // a request held at the full rate must not freeze the tick: only a slow cycle restarts
        if (slowNow) begin
          cycCnt_ff <= 10'h000;
        end else if (cycCnt_ff >= divMax) begin
          cycCnt_ff <= 10'h000;
        end else begin
          cycCnt_ff <= cycCnt_ff + 10'h001;
        end
      end else begin
        if (cycCnt_ff >= divMax) begin
          cycCnt_ff <= 10'h000;
          if (pendValid_ff) begin
            divSel_ff <= divPend_ff;
            pendValid_ff <= 1'b0;
          end
        end else begin
          cycCnt_ff <= cycCnt_ff + 10'h001;
        end
        if (wrPmr && divWriteOk) begin
          divPend_ff <= wrDiv;
          pendValid_ff <= 1'b1;
        end
      end
    end
  end

  // crystal warm-up after the amplifier is re-enabled
  // limitation: the warm-up counts this clock, not the crystal's own edges
  always @(posedge clk) begin
    if (reset || coreReset) begin
      xtalCnt_ff <= 17'h00000;
      xtalUp_ff <= 1'b0;
    end else if (xtalOff_ff) begin
      xtalCnt_ff <= 17'h00000;
      xtalUp_ff <= 1'b0;
    end else if (!xtalUp_ff) begin
      xtalCnt_ff <= xtalCnt_ff + 17'h00001;
      xtalUp_ff <= (xtalCnt_ff == XTAL_WARM_CYCLES[16:0] - 17'h00001);
    end
  end

  // control bits; source selection never touched by switchback
  // crystal-off only sticks while the ring is the source, or the core would lose its clock
  always @(posedge clk) begin
    if (reset || coreReset) begin
      autoRet_ff <= 1'b0;
      xtalOff_ff <= 1'b0;
      xtalSel_ff <= 1'b1;
      ringSelect <= 1'b0;
    end else begin
      if (wrPmr) begin
        autoRet_ff <= writedata[`PRSC_PMR_AUTO_RET];
        xtalOff_ff <= writedata[`PRSC_PMR_XTAL_OFF] & ~xtalSel_ff;
      end
      if (wrExif) begin
        if (!writedata[`PRSC_EXT_INTERRUPT_FLAGS_XTAL_SEL] || (xtalUp_ff && !xtalOff_ff)) begin
          xtalSel_ff <= writedata[`PRSC_EXT_INTERRUPT_FLAGS_XTAL_SEL];
        end
      end
      // source status lags the selection by one clock
      ringSelect <= ~xtalSel_ff;
    end
  end

  // power-on flag: set by the power-up release, cleared by software; set wins
  // only the warm-up to run step sets it, so a bench reset alone leaves it clear
  always @(posedge clk) begin
    if (reset) begin
      porFlag_ff <= 1'b0;
    end else if (state_ff == ST_WARM && nxt_state == ST_RUN) begin
      porFlag_ff <= 1'b1;
    end else if (wrWdc) begin
      porFlag_ff <= writedata[`PRSC_WDC_POR] & porFlag_ff;
    end
  end

  always @(posedge clk) begin
    if (reset) begin
      divSelOut <= `PRSC_DIV_4;
    end else begin
      divSelOut <= divSel_ff;
    end
  end

  // register views; unused bits read as zero
  assign pmrView = {divSel_ff, autoRet_ff, 1'b0, xtalOff_ff, 3'h0};
  assign statusView = {pfInService, hiInService, loInService, xtalUp_ff, 2'h0,
    serialTxActive, serialRxActive | serialBusy_ff};
  assign exifView = {4'h0, xtalSel_ff, ringSelect, 2'h0};
  assign wdcView = {1'b0, porFlag_ff, 6'h00};

  // read data registered on the request's first edge; unmapped reads give zero
  always @(posedge clk) begin
    if (reset) begin
      readdata <= 8'h00;
    end else if (rdTake) begin
      case (address)
        `PRSC_OFF_POWER_MGMT:
          readdata <= pmrView;
        `PRSC_OFF_POWER_STATUS:
          readdata <= statusView;
        `PRSC_OFF_EXT_INT_FLAGS:
          readdata <= exifView;
        `PRSC_OFF_WATCHDOG_CTL:
          readdata <= wdcView;
        default:
          readdata <= 8'h00;
      endcase
    end
  end
endmodule

// ==== test/prsc_ctl_assertions.sv ====
// port assertions for the power/slow-clock block
`timescale 1ns/1ns
module prsc_ctl_assertions #(
  parameter OSC_CYCLES = 65536
) (
  input wire clk,
  input wire reset,
  input wire read,
  input wire write,
  input wire waitrequest,
  input wire supplyLowPin,
  input wire sysResetOutN,
  input wire coreReset,
  input wire ioReset,
  input wire xtalEnable,
  input wire [15:0] resetVector,
  input wire cycleTick,
  input wire [1:0] divSelOut
);
  reg [31:0] lowCnt_ff;
  reg [10:0] gap_ff;
  reg [1:0] seen_ff;
  reg [1:0] divPrev_ff;
  // gap is judged only two ticks after a rate change, so a half-old interval never counts
  always @(posedge clk) begin
    divPrev_ff <= divSelOut;
    lowCnt_ff <= (reset || supplyLowPin) ? 32'h0 : lowCnt_ff + 32'h1;
    gap_ff <= (reset || cycleTick) ? 11'h000 : gap_ff + 11'h001;
    if (reset || coreReset || divSelOut != divPrev_ff) seen_ff <= 2'h0;
    else if (cycleTick && seen_ff != 2'h3) seen_ff <= seen_ff + 2'h1;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  a_supply_hold: assert property (supplyLowPin [*5] |-> !sysResetOutN && coreReset && ioReset)
    else $error("core not held in reset while supply low");
  a_warm_xtal: assert property ((!supplyLowPin && !sysResetOutN) [*8] |-> xtalEnable)
    else $error("crystal off during warm-up");
  a_warm_count: assert property ($rose(sysResetOutN) |-> lowCnt_ff >= OSC_CYCLES && lowCnt_ff <= OSC_CYCLES + 6)
    else $error("warm-up length wrong");
  a_core_release: assert property ($rose(sysResetOutN) |-> ##[0:1] (!coreReset && !ioReset))
    else $error("core not released with reset output");
  a_start_vector: assert property (!coreReset |-> resetVector == 16'h0000)
    else $error("start address not zero");
  a_tick_gap: assert property (cycleTick && seen_ff >= 2'h2 |-> gap_ff == (divSelOut == 2'h1 ? 11'h003 : divSelOut == 2'h2 ? 11'h03F : 11'h3FF))
    else $error("instruction tick spacing wrong");
  a_div_code: assert property (divSelOut != 2'h0)
    else $error("reserved divider code in use");
  a_slow_direct: assert property (divSelOut[1] |=> divSelOut == $past(divSelOut) || divSelOut == 2'h1)
    else $error("direct move between slow rates");
  a_bus_wait: assert property ($rose(read || write) |-> waitrequest ##1 !waitrequest)
    else $error("wait state count wrong");
  c_power_up: cover property ($rose(sysResetOutN));
  c_slow_64: cover property (cycleTick && divSelOut == 2'h2);
  c_slow_1024: cover property (cycleTick && divSelOut == 2'h3);
  c_switchback: cover property (divSelOut[1] ##1 divSelOut == 2'h1);
endmodule

// ==== test/tb_power_reset_and_slow_clock_ctl.sv ====
// self-checking bench for the power/slow-clock block
`timescale 1ns/1ns
module tb_power_reset_and_slow_clock_ctl;
  reg clk = 0, reset = 1, read = 0, write = 0, supplyLowPin = 1, globalIntEnable = 1;
  reg pfInService = 0, hiInService = 0, loInService = 0, serialRxPin = 1;
  reg serialRxEnable = 0, serialRxActive = 0, serialTxActive = 0;
  reg [7:0] address = 8'h00, writedata = 8'h00, rd;
  reg [5:0] extIntPin = 6'h00, extIntEnable = 6'h01, extIntHighPri = 6'h00;
  // each row: value written to the power register, divider code expected after it
  reg [9:0] row [0:6] = '{10'h001, 10'h202, 10'h302, 10'h101, 10'h303, 10'h203, 10'h101};
  wire [7:0] readdata;
  wire waitrequest, sysResetOutN, coreReset, ioReset, xtalEnable, cycleTick, ringSelect;
  wire [15:0] resetVector;
  wire [1:0] divSelOut;
  int fails = 0, total_checks = 0, cyc = 0, i;
  prsc_power_clock_ctl #(.OSC_CYCLES(16), .XTAL_WARM_CYCLES(16)) uut (.clk, .reset, .address,
    .read, .write, .writedata, .readdata, .waitrequest, .supplyLowPin, .sysResetOutN,
    .coreReset, .ioReset, .xtalEnable, .resetVector, .cycleTick, .divSelOut, .ringSelect,
    .extIntPin, .extIntEnable, .extIntHighPri, .globalIntEnable, .pfInService, .hiInService,
    .loInService, .serialRxPin, .serialRxEnable, .serialRxActive, .serialTxActive);
  initial forever #5 clk = ~clk;
  task chk(input [15:0] got, input [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // request held until waitrequest is seen low at a rising edge; read data taken there
  task bus(input w, input [7:0] a, input [7:0] d);
    @(posedge clk);
    address <= a;
    writedata <= d;
    read <= !w;
    write <= w;
    do @(posedge clk); while (waitrequest !== 1'b0);
    rd = readdata;
    read <= 0;
    write <= 0;
  endtask
  task ticks(input int n);
    while (n > 0) begin
      @(posedge clk);
      #1;
      if (cycleTick === 1'b1) n--;
    end
  endtask
  task settle(input [1:0] e);
    repeat (12) if (divSelOut !== e) begin
      @(posedge clk);
      #1;
    end
  endtask
  task complete_run;
    $display("checks %0d failures %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      complete_run;
    end
  end
  initial begin
    repeat (6) @(posedge clk);
    reset <= 0;
    repeat (8) @(posedge clk);
    #1;
    chk({sysResetOutN, coreReset, ioReset}, 3'b011);
    @(posedge clk);
    supplyLowPin <= 0;
    i = 0;
    while (sysResetOutN !== 1'b1) begin
      @(posedge clk);
      #1;
      i++;
    end
    chk(i >= 16 && i <= 24, 1);
    chk({coreReset, ioReset, xtalEnable}, 3'b001);
    chk(resetVector, 16'h0000);
    bus(0, 8'hC6, 0);
    chk(rd[6], 1);
    bus(1, 8'hC6, 8'h00);
    bus(0, 8'hC6, 0);
    chk(rd[6], 0);
    bus(0, 8'h10, 0);
    chk(rd, 0);
    $display("test power-up done");
    for (i = 0; i < 7; i++) begin
      bus(1, 8'hC4, row[i][9:2]);
      #1;
      chk(divSelOut, i ? row[i-1][1:0] : 2'h1);
      ticks(2);
      chk(divSelOut, row[i][1:0]);
    end
    $display("test divider table done");
    bus(1, 8'hC4, 8'h80);
    ticks(2);
    @(posedge clk);
    extIntPin <= 6'h01;
    hiInService <= 1;
    repeat (20) @(posedge clk);
    #1;
    chk(divSelOut, 2'h2);
    bus(1, 8'hC4, 8'hA0);
    repeat (20) @(posedge clk);
    #1;
    chk(divSelOut, 2'h2);
    @(posedge clk);
    hiInService <= 0;
    settle(2'h1);
    chk(divSelOut, 2'h1);
    $display("test interrupt switchback done");
    @(posedge clk);
    extIntPin <= 6'h00;
    serialTxActive <= 1;
    bus(1, 8'hC4, 8'h80);
    ticks(2);
    chk(divSelOut, 2'h1);
    @(posedge clk);
    serialTxActive <= 0;
    serialRxEnable <= 1;
    bus(1, 8'h91, 8'h00);
    bus(1, 8'hC4, 8'hA0);
    ticks(2);
    chk({ringSelect, divSelOut}, 3'h6);
    @(posedge clk);
    serialRxPin <= 0;
    settle(2'h1);
    chk({ringSelect, divSelOut}, 3'h5);
    bus(1, 8'hC4, 8'hA0);
    ticks(2);
    chk(divSelOut, 2'h1);
    $display("test serial switchback done");
    @(posedge clk);
    supplyLowPin <= 1;
    serialRxPin <= 1;
    repeat (8) @(posedge clk);
    #1;
    chk({sysResetOutN, coreReset, ioReset, divSelOut, ringSelect}, 6'h1A);
    @(posedge clk);
    supplyLowPin <= 0;
    while (sysResetOutN !== 1'b1) @(posedge clk);
    bus(0, 8'hC6, 0);
    chk(rd[6], 1);
    $display("test brownout done");
    @(posedge clk);
    reset <= 1;
    repeat (2) @(posedge clk);
    #1;
    chk({sysResetOutN, divSelOut, cycleTick}, 4'h2);
    @(posedge clk);
    reset <= 0;
    while (sysResetOutN !== 1'b1) @(posedge clk);
    $display("test second reset done");
    complete_run;
  end
endmodule
bind prsc_power_clock_ctl prsc_ctl_assertions #(.OSC_CYCLES(OSC_CYCLES)) sva (.clk, .reset,
  .read, .write, .waitrequest, .supplyLowPin, .sysResetOutN, .coreReset, .ioReset,
  .xtalEnable, .resetVector, .cycleTick, .divSelOut);
